// ==== hw/wwsb_pkg.sv ====
// constants, types and decode functions shared by both ends of the socket sideband link
package wwsb_pkg;
  localparam int PIN_COUNT = 12;
  localparam int STRAP_COUNT = 4;
  localparam int CLK_HZ = 50_000_000;
  // wake pulse length in ms (1 s)
  localparam int WAKE_PULSE_MS = 1000;
  localparam int WAKE_CYCLES = WAKE_PULSE_MS * (CLK_HZ / 1000);
  localparam int WAKE_CNT_W = 26;
  // radio sync clock half period, build option
  localparam int SYNC_HALF_CYCLES = 4;
  localparam int SYNC_CNT_W = 8;
  // host debounce window for the proximity sensor
  localparam int PROX_DEBOUNCE_US = 1000;
  localparam int PROX_DEBOUNCE_CYCLES = PROX_DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int PROX_CNT_W = 20;
  // card state the device presents by default
  localparam logic [3:0] DEV_STATE_DEFAULT = 4'h2;
  localparam logic [3:0] STATE_EMPTY = 4'hF;
  // host register map, byte addresses
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PIN_IN = 8'h08;
  localparam logic [7:0] REG_PIN_OUT = 8'h0C;
  localparam logic [7:0] REG_PIN_DRV = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_PROX_EN_BIT = 2;
  localparam int CTRL_IPC78_BIT = 3;
  localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_KIND_LSB = 4;
  localparam int ST_PROFILE_LSB = 8;
  localparam int ST_WAKE_BIT = 12;
  localparam int ST_PROX_BIT = 13;

  typedef enum {
    FN_LOC_SCL, FN_LOC_SDA, FN_LOC_IRQ, FN_SYNC_CLK, FN_TX_BLANK, FN_AUX, FN_VOICE,
    FN_ACT_N, FN_RADIO_OFF2, FN_WAKE_N, FN_SIM, FN_IPC, FN_HSIC, FN_RSVD
  } wwsb_fn_t;

  typedef enum logic [2:0] {
    CK_SATA_SSD, CK_PCIE_SSD, CK_PCIE_RADIO, CK_USB3_RADIO, CK_SSIC_RADIO,
    CK_RSVD, CK_EMPTY
  } wwsb_kind_t;

  function automatic wwsb_kind_t kind_of(input logic [3:0] st);
    if (st == 4'h0) return CK_SATA_SSD;
    else if (st == 4'h1) return CK_PCIE_SSD;
    else if (st == 4'h2 || st == 4'h3 || st == 4'hC || st == 4'hD) return CK_PCIE_RADIO;
    else if (st >= 4'h4 && st <= 4'h7) return CK_USB3_RADIO;
    else if (st >= 4'h8 && st <= 4'hB) return CK_SSIC_RADIO;
    else if (st == 4'hE) return CK_RSVD;
    else return CK_EMPTY;
  endfunction

  function automatic logic [1:0] profile_of(input logic [3:0] st);
    if (st == 4'h3) return 2'h1;
    else if (st == 4'hC) return 2'h2;
    else if (st == 4'hD) return 2'h3;
    else if (st >= 4'h4 && st <= 4'hB) return st[1:0];
    else return 2'h0;
  endfunction

  function automatic logic is_radio(input logic [3:0] st);
    wwsb_kind_t k;
    k = kind_of(st);
    return (k == CK_PCIE_RADIO || k == CK_USB3_RADIO || k == CK_SSIC_RADIO);
  endfunction

  // function of one sideband pin for a card state; non-radio states get none
  function automatic wwsb_fn_t pin_func(input logic [3:0] st, input int pin,
                                        input logic ipc78);
    logic [1:0] p;
    p = profile_of(st);
    if (!is_radio(st)) return FN_RSVD;
    if (p == 2'h2) begin
      if (pin == 0) return FN_SIM;
      else if (pin <= 4) return FN_SIM;
      else if (pin <= 8) return FN_RSVD;
    end else if (p == 2'h3) begin
      if (pin <= 4) return FN_IPC;
      else if (pin <= 6) return FN_VOICE;
      else if (pin <= 8) return ipc78 ? FN_IPC : FN_VOICE;
      else if (pin == 9) return FN_IPC;
      else return FN_HSIC;
    end else begin
      if (pin == 0) return FN_LOC_SCL;
      else if (pin == 1) return FN_LOC_SDA;
      else if (pin == 2) return FN_LOC_IRQ;
      else if (pin == 3) return (p == 2'h1) ? FN_AUX : FN_SYNC_CLK;
      else if (pin == 4) return (p == 2'h1) ? FN_AUX : FN_TX_BLANK;
      else if (pin <= 8) return FN_VOICE;
    end
    if (pin == 9) return FN_ACT_N;
    else if (pin == 10) return FN_RADIO_OFF2;
    else return FN_WAKE_N;
  endfunction

  // strap bits as pins: strap 0 is state bit 3, straps 3..1 are bits 2..0
  function automatic logic [3:0] strap_of(input logic [3:0] st);
    return {st[2], st[1], st[0], st[3]};
  endfunction
endpackage

// ==== hw/wwsb_if.sv ====
// pin level carrier between the card and the host, with pull-ups resolved here
interface wwsb_if;
  import wwsb_pkg::*;
  logic module_kill_n;
  logic modem_rst_n;
  logic prox_cut;
  logic [STRAP_COUNT-1:0] strap_oe_n;
  logic [STRAP_COUNT-1:0] strap_level;
  logic [PIN_COUNT-1:0] dev_pin_out;
  logic [PIN_COUNT-1:0] dev_pin_oe_n;
  logic [PIN_COUNT-1:0] host_pin_out;
  logic [PIN_COUNT-1:0] host_pin_oe_n;
  logic [PIN_COUNT-1:0] pin_level;

  // host pull-ups: an open strap reads one, a grounded one zero
  assign strap_level = strap_oe_n;
  // wired-and with pull-up: an undriven pin reads one
  assign pin_level = (dev_pin_oe_n | dev_pin_out) & (host_pin_oe_n | host_pin_out);

  modport dev (
    input module_kill_n, modem_rst_n, prox_cut, pin_level,
    output strap_oe_n, dev_pin_out, dev_pin_oe_n
  );
  modport host (
    input strap_level, pin_level,
    output module_kill_n, modem_rst_n, prox_cut, host_pin_out, host_pin_oe_n
  );
endinterface

// ==== hw/wwsb_dev.sv ====
// card end: straps, kill and reset handling, sideband pin functions
module wwsb_dev #(
  parameter logic [3:0] CARD_STATE = wwsb_pkg::DEV_STATE_DEFAULT,
  parameter logic IPC_ON_78 = 1'b0,
  parameter int WAKE_CYCLES = wwsb_pkg::WAKE_CYCLES,
  parameter int SYNC_HALF = wwsb_pkg::SYNC_HALF_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  wwsb_if.dev link,
  input wire logic loc_sda_low_i,
  input wire logic loc_irq_assert_i,
  input wire logic tx_swamp_i,
  input wire logic activity_i,
  input wire logic wake_req_i,
  input wire logic net_attach_i,
  input wire logic [wwsb_pkg::PIN_COUNT-1:0] gp_out_i,
  input wire logic [wwsb_pkg::PIN_COUNT-1:0] gp_drive_i,
  output logic [wwsb_pkg::PIN_COUNT-1:0] gp_in_o,
  output logic loc_scl_o,
  output logic loc_sda_o,
  output logic loc_irq_o,
  output logic radio_off_o,
  output logic wake_busy_o,
  output logic tx_power_cut_o,
  output logic modem_run_o,
  output logic net_connected_o
);
  import wwsb_pkg::*;

  // refuse counts the counters cannot hold, at elaboration
  if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << WAKE_CNT_W)) begin : g_bad_wake
    $error("WAKE_CYCLES out of range");
  end
  if (SYNC_HALF < 1 || SYNC_HALF > (1 << SYNC_CNT_W)) begin : g_bad_sync
    $error("SYNC_HALF out of range");
  end

  localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CNT_W'(WAKE_CYCLES - 1);
  localparam logic [SYNC_CNT_W-1:0] SYNC_LOAD = SYNC_CNT_W'(SYNC_HALF - 1);

  logic halt;
  logic [PIN_COUNT-1:0] lvl;
  logic [PIN_COUNT-1:0] out_nxt;
  logic [PIN_COUNT-1:0] oe_n_nxt;
  logic [PIN_COUNT-1:0] pin_out_r;
  logic [PIN_COUNT-1:0] pin_oe_n_r;
  logic [PIN_COUNT-1:0] m_scl;
  logic [PIN_COUNT-1:0] m_sda;
  logic [PIN_COUNT-1:0] m_irq;
  logic [PIN_COUNT-1:0] m_off;
  logic [STRAP_COUNT-1:0] strap_oe_n_r;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic wake_busy_r;
  logic [SYNC_CNT_W-1:0] sync_cnt_r;
  logic sync_clk_r;
  logic prox_meta_r;
  logic prox_sync_r;
  logic run_r;
  logic net_r;
  logic [PIN_COUNT-1:0] gp_in_r;
  logic loc_scl_r;
  logic loc_sda_r;
  logic loc_irq_r;
  logic radio_off_r;
  logic loc_scl_nxt;
  logic loc_sda_nxt;
  logic loc_irq_nxt;
  logic radio_off_nxt;

  // either pin low shuts the card; no clock needed to enter it
  assign halt = ~link.module_kill_n | ~link.modem_rst_n;
  assign lvl = link.pin_level;

  // per-pin function is fixed by the presented card state
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    localparam wwsb_fn_t FN = pin_func(CARD_STATE, i, IPC_ON_78);
    assign m_scl[i] = (FN == FN_LOC_SCL);
    assign m_sda[i] = (FN == FN_LOC_SDA);
    assign m_irq[i] = (FN == FN_LOC_IRQ);
    assign m_off[i] = (FN == FN_RADIO_OFF2);
    always_comb begin
      out_nxt[i] = 1'b0;
      oe_n_nxt[i] = 1'b1;
      case (FN)
        FN_RSVD: oe_n_nxt[i] = 1'b1;
        FN_LOC_SCL: oe_n_nxt[i] = 1'b1;
        FN_RADIO_OFF2: oe_n_nxt[i] = 1'b1;
        FN_LOC_SDA: oe_n_nxt[i] = ~loc_sda_low_i;
        FN_LOC_IRQ: oe_n_nxt[i] = ~loc_irq_assert_i;
        FN_SYNC_CLK: begin
          out_nxt[i] = sync_clk_r;
          oe_n_nxt[i] = 1'b0;
        end
        FN_TX_BLANK: begin
          out_nxt[i] = tx_swamp_i;
          oe_n_nxt[i] = 1'b0;
        end
        FN_ACT_N: oe_n_nxt[i] = ~activity_i;
        FN_WAKE_N: oe_n_nxt[i] = ~wake_busy_r;
        default: begin
          out_nxt[i] = gp_out_i[i];
          oe_n_nxt[i] = ~gp_drive_i[i];
        end
      endcase
    end
  end

  // inputs that the card reads from its function pins
  assign loc_scl_nxt = |(lvl & m_scl);
  assign loc_sda_nxt = |(lvl & m_sda);
  assign loc_irq_nxt = |(~lvl & m_irq);
  assign radio_off_nxt = |(~lvl & m_off);

  // pin drivers; everything released while shut down
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end else if (rst_i) begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_n_r <= oe_n_nxt;
    end
  end

  // sampled pin levels for the card logic
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      gp_in_r <= '0;
      loc_scl_r <= 1'b0;
      loc_sda_r <= 1'b0;
      loc_irq_r <= 1'b0;
      radio_off_r <= 1'b0;
    end else if (rst_i) begin
      gp_in_r <= '0;
      loc_scl_r <= 1'b0;
      loc_sda_r <= 1'b0;
      loc_irq_r <= 1'b0;
      radio_off_r <= 1'b0;
    end else begin
      gp_in_r <= lvl;
      loc_scl_r <= loc_scl_nxt;
      loc_sda_r <= loc_sda_nxt;
      loc_irq_r <= loc_irq_nxt;
      radio_off_r <= radio_off_nxt;
    end
  end

  // wake pulse; a request during a pulse is absorbed, not queued
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      wake_busy_r <= 1'b0;
      wake_cnt_r <= '0;
    end else if (rst_i) begin
      wake_busy_r <= 1'b0;
      wake_cnt_r <= '0;
    end else if (wake_req_i && !wake_busy_r) begin
      wake_busy_r <= 1'b1;
      wake_cnt_r <= WAKE_LOAD;
    end else if (wake_busy_r) begin
      if (wake_cnt_r == '0) begin
        wake_busy_r <= 1'b0;
      end else begin
        wake_cnt_r <= wake_cnt_r - 1'b1;
      end
    end
  end

  // sync clock divider, free running while the card runs
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      sync_cnt_r <= '0;
      sync_clk_r <= 1'b0;
    end else if (rst_i) begin
      sync_cnt_r <= '0;
      sync_clk_r <= 1'b0;
    end else if (sync_cnt_r == SYNC_LOAD) begin
      sync_cnt_r <= '0;
      sync_clk_r <= ~sync_clk_r;
    end else begin
      sync_cnt_r <= sync_cnt_r + 1'b1;
    end
  end

  // proximity has no timing relation to us, so two flops first
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      prox_meta_r <= 1'b0;
      prox_sync_r <= 1'b0;
    end else if (rst_i) begin
      prox_meta_r <= 1'b0;
      prox_sync_r <= 1'b0;
    end else begin
      prox_meta_r <= link.prox_cut;
      prox_sync_r <= prox_meta_r;
    end
  end

  // run state and network session; a reset loses the session until the next attach
  always_ff @(posedge core_clk_i or posedge halt) begin
    if (halt) begin
      run_r <= 1'b0;
      net_r <= 1'b0;
    end else if (rst_i) begin
      run_r <= 1'b0;
      net_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
      net_r <= net_r | (net_attach_i & run_r);
    end
  end

  // straps are passive grounds, kept even when the card is shut down
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      strap_oe_n_r <= strap_of(CARD_STATE);
    end else begin
      strap_oe_n_r <= strap_of(CARD_STATE);
    end
  end

  assign link.strap_oe_n = strap_oe_n_r;
  assign link.dev_pin_out = pin_out_r;
  assign link.dev_pin_oe_n = pin_oe_n_r;
  assign gp_in_o = gp_in_r;
  assign loc_scl_o = loc_scl_r;
  assign loc_sda_o = loc_sda_r;
  assign loc_irq_o = loc_irq_r;
  assign radio_off_o = radio_off_r;
  assign wake_busy_o = wake_busy_r;
  assign tx_power_cut_o = prox_sync_r;
  assign modem_run_o = run_r;
  assign net_connected_o = net_r;
endmodule

// ==== hw/wwsb_host.sv ====
// host end: strap decode, card control and sideband pin access through registers
module wwsb_host #(
  parameter int PROX_CYCLES = wwsb_pkg::PROX_DEBOUNCE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  wwsb_if.host link,
  input wire logic [wwsb_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [wwsb_pkg::REG_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [wwsb_pkg::REG_DW-1:0] reg_rdata_o,
  input wire logic prox_sensor_i,
  output logic card_present_o
);
  import wwsb_pkg::*;

  // refuse a window the debounce counter cannot hold, at elaboration
  if (PROX_CYCLES < 1 || PROX_CYCLES >= (1 << PROX_CNT_W)) begin : g_bad_prox
    $error("PROX_CYCLES out of range");
  end

  localparam logic [PROX_CNT_W-1:0] PROX_LOAD = PROX_CNT_W'(PROX_CYCLES - 1);

  logic [3:0] ctrl_r;
  logic [3:0] state_r;
  logic [PIN_COUNT-1:0] out_r;
  logic [PIN_COUNT-1:0] drv_r;
  logic [PIN_COUNT-1:0] pin_oe_n_r;
  logic [PIN_COUNT-1:0] allow;
  logic [PIN_COUNT-1:0] m_wake;
  logic wake_lvl_r;
  logic wake_seen_r;
  logic prox_stable_r;
  logic [PROX_CNT_W-1:0] prox_cnt_r;
  logic prox_r;
  logic present_r;
  logic [REG_DW-1:0] rdata_r;
  logic [REG_DW-1:0] status;
  logic [REG_DW-1:0] rd_nxt;
  logic wake_lvl_nxt;
  logic wake_clr;

  // which pins the host may drive for the decoded card
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_allow
    wwsb_fn_t fn;
    assign fn = pin_func(state_r, i, ctrl_r[CTRL_IPC78_BIT]);
    assign allow[i] = !(fn == FN_RSVD || fn == FN_SYNC_CLK || fn == FN_TX_BLANK ||
                        fn == FN_ACT_N || fn == FN_WAKE_N);
    assign m_wake[i] = (fn == FN_WAKE_N);
  end

  assign wake_lvl_nxt = |(~link.pin_level & m_wake);
  assign wake_clr = reg_wr_i && (reg_addr_i == REG_STATUS) && reg_wdata_i[ST_WAKE_BIT];
  assign status = {18'h0, prox_r, wake_seen_r, 2'h0, profile_of(state_r), 1'b0,
                   kind_of(state_r), state_r};
  // register read select, unmapped reads give zero
  assign rd_nxt = (reg_addr_i == REG_CTRL) ? {28'h0, ctrl_r} :
                  (reg_addr_i == REG_STATUS) ? status :
                  (reg_addr_i == REG_PIN_IN) ? {20'h0, link.pin_level} :
                  (reg_addr_i == REG_PIN_OUT) ? {20'h0, out_r} :
                  (reg_addr_i == REG_PIN_DRV) ? {20'h0, drv_r} : 32'h0;

  // register writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET_VAL;
      out_r <= '0;
      drv_r <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_CTRL) ctrl_r <= reg_wdata_i[3:0];
      else if (reg_addr_i == REG_PIN_OUT) out_r <= reg_wdata_i[PIN_COUNT-1:0];
      else if (reg_addr_i == REG_PIN_DRV) drv_r <= reg_wdata_i[PIN_COUNT-1:0];
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) rdata_r <= '0;
    else rdata_r <= reg_rd_i ? rd_nxt : 32'h0;
  end

  // strap sampling in host bit order, pin drives gated by decode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= STATE_EMPTY;
      present_r <= 1'b0;
      pin_oe_n_r <= '1;
    end else begin
      state_r <= {link.strap_level[0], link.strap_level[3], link.strap_level[2],
                  link.strap_level[1]};
      present_r <= (state_r != STATE_EMPTY);
      pin_oe_n_r <= ~(drv_r & allow);
    end
  end

  // wake seen is sticky; a new fall beats a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wake_lvl_r <= 1'b0;
      wake_seen_r <= 1'b0;
    end else begin
      wake_lvl_r <= wake_lvl_nxt;
      if (wake_lvl_nxt && !wake_lvl_r) wake_seen_r <= 1'b1;
      else if (wake_clr) wake_seen_r <= 1'b0;
    end
  end

  // sensor level must hold a full window before it counts
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prox_stable_r <= 1'b0;
      prox_cnt_r <= '0;
      prox_r <= 1'b0;
    end else begin
      if (prox_sensor_i == prox_stable_r) prox_cnt_r <= '0;
      else if (prox_cnt_r == PROX_LOAD) begin
        prox_stable_r <= prox_sensor_i;
        prox_cnt_r <= '0;
      end else prox_cnt_r <= prox_cnt_r + 1'b1;
      prox_r <= prox_stable_r & ctrl_r[CTRL_PROX_EN_BIT];
    end
  end

  // the link carries no factory pins, so the host leaves them open
  assign link.module_kill_n = ctrl_r[CTRL_ENABLE_BIT];
  assign link.modem_rst_n = ~ctrl_r[CTRL_RESET_BIT];
  assign link.prox_cut = prox_r;
  assign link.host_pin_out = out_r;
  assign link.host_pin_oe_n = pin_oe_n_r;
  assign reg_rdata_o = rdata_r;
  assign card_present_o = present_r;
endmodule

// ==== tb/wwsb_checker.sv ====
// assertions on the card-to-host sideband link signals
module wwsb_checker #(
  parameter logic [3:0] CARD_STATE = 4'h2,
  parameter int WAKE_CYCLES = 20,
  parameter int SYNC_HALF = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic module_kill_n,
  input wire logic modem_rst_n,
  input wire logic [3:0] strap_oe_n,
  input wire logic [11:0] dev_pin_out,
  input wire logic [11:0] dev_pin_oe_n,
  input wire logic [11:0] host_pin_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic halt;
  logic [7:0] wake_cnt_r;
  logic [7:0] wake_cnt_nxt;

  // halt is a plain level: the card must not wait for an edge to stop
  assign halt = !module_kill_n || !modem_rst_n;
  // run length of the wake drive; 8 bits only suit shortened pulses
  assign wake_cnt_nxt = dev_pin_oe_n[11] ? 8'h00 : wake_cnt_r + 8'h01;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) wake_cnt_r <= 8'h00;
    else wake_cnt_r <= wake_cnt_nxt;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_kill_release: assert property (!module_kill_n |-> &dev_pin_oe_n && dev_pin_out == 12'h000)
    else $error("card drives pins while killed");
  a_reset_release: assert property (!modem_rst_n |-> &dev_pin_oe_n)
    else $error("card drives pins while in modem reset");
  a_strap_fixed: assert property (strap_oe_n == {CARD_STATE[2:0], CARD_STATE[3]})
    else $error("strap pattern does not match card state");
  // pin 0 is the location clock in profiles 0 and 1; the card only listens
  a_scl_input: assert property (dev_pin_oe_n[0])
    else $error("card drives location clock");
  a_sync_period: assert property (disable iff (rst_i || halt)
    $rose(dev_pin_out[3]) |-> ##SYNC_HALF $fell(dev_pin_out[3]))
    else $error("sync clock half period wrong");
  a_wake_length: assert property (disable iff (rst_i || halt)
    $rose(dev_pin_oe_n[11]) |-> wake_cnt_r == WAKE_CYCLES)
    else $error("wake pulse length wrong");
  a_wake_bound: assert property (wake_cnt_r <= WAKE_CYCLES)
    else $error("wake pulse too long");
  a_wake_low: assert property (!dev_pin_oe_n[11] |-> !dev_pin_out[11])
    else $error("wake pin driven high");
  a_irq_low: assert property (!dev_pin_oe_n[2] |-> !dev_pin_out[2])
    else $error("interrupt pin driven high");
  a_host_keeps_off: assert property (&host_pin_oe_n[4:3] && host_pin_oe_n[9] && host_pin_oe_n[11])
    else $error("host drives a card output pin");
  a_off_after_reset: assert property (disable iff (1'b0) rst_i |=> !module_kill_n)
    else $error("card enabled straight after reset");

  c_wake: cover property ($fell(dev_pin_oe_n[11]));
  c_kill: cover property ($fell(module_kill_n));
  c_modem_reset: cover property ($fell(modem_rst_n));
endmodule

// ==== tb/wwsb_bench.sv ====
// self-checking bench: card and host ends joined over the sideband link
module wwsb_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import wwsb_pkg::*;
  localparam int WAKE_N = 20;
  localparam int PROX_N = 8;
  localparam int SYNC_N = 4;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic sda_low = 1'b0, irq_req = 1'b0, swamp = 1'b0, act = 1'b0;
  logic wake_req = 1'b0, attach = 1'b0, prox = 1'b0;
  logic [11:0] gp_out = 12'h000;
  logic [11:0] gp_drv = 12'h000;
  logic [11:0] gp_in;
  logic scl, sda, irq, roff, busy, cut, run, net, present;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  int w;

  wwsb_if link ();

  wwsb_dev #(.CARD_STATE(4'h2), .WAKE_CYCLES(WAKE_N), .SYNC_HALF(SYNC_N)) wwsb_dev_inst (
    .core_clk_i(core_clk), .rst_i(rst), .link(link.dev), .loc_sda_low_i(sda_low),
    .loc_irq_assert_i(irq_req), .tx_swamp_i(swamp), .activity_i(act), .wake_req_i(wake_req),
    .net_attach_i(attach), .gp_out_i(gp_out), .gp_drive_i(gp_drv), .gp_in_o(gp_in),
    .loc_scl_o(scl), .loc_sda_o(sda), .loc_irq_o(irq), .radio_off_o(roff), .wake_busy_o(busy),
    .tx_power_cut_o(cut), .modem_run_o(run), .net_connected_o(net));

  wwsb_host #(.PROX_CYCLES(PROX_N)) wwsb_host_inst (
    .core_clk_i(core_clk), .rst_i(rst), .link(link.host), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .prox_sensor_i(prox), .card_present_o(present));

  wwsb_checker #(.CARD_STATE(4'h2), .WAKE_CYCLES(WAKE_N), .SYNC_HALF(SYNC_N)) wwsb_checker_inst (
    .core_clk_i(core_clk), .rst_i(rst), .module_kill_n(link.module_kill_n),
    .modem_rst_n(link.modem_rst_n), .strap_oe_n(link.strap_oe_n),
    .dev_pin_out(link.dev_pin_out), .dev_pin_oe_n(link.dev_pin_oe_n),
    .host_pin_oe_n(link.host_pin_oe_n));

  always #10 core_clk = ~core_clk;

  // hang guard: the whole sequence needs about 130 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobes; the task returns just after the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe, so look there
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                        input string what);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(what, exp & m, rdata & m);
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // after reset the card is held off; state 2 is a pcie radio in profile 0
    rd_reg(REG_CTRL, 32'h00000000, ALL, "ctrl");
    chk("run off", 32'h0, {31'h0, run});
    rd_reg(REG_STATUS, 32'h00000022, ALL, "status");
    chk("straps", 32'h4, {28'h0, link.strap_level});
    chk("present", 32'h1, {31'h0, present});
    rd_reg(8'h40, 32'h00000000, ALL, "unmapped");
    wr_reg(8'h40, 32'h00000001);
    rd_reg(REG_CTRL, 32'h00000000, ALL, "ctrl kept");
    $display("test reset done");
    // enable, attach, then modem reset must drop run and the network session at once
    wr_reg(REG_CTRL, 32'h00000001);
    wait_cyc(2);
    chk("run on", 32'h1, {31'h0, run});
    @(posedge core_clk);
    attach <= 1'b1;
    @(posedge core_clk);
    attach <= 1'b0;
    wait_cyc(1);
    chk("net up", 32'h1, {31'h0, net});
    wr_reg(REG_CTRL, 32'h00000003);
    chk("reset run", 32'h0, {31'h0, run});
    chk("reset net", 32'h0, {31'h0, net});
    wr_reg(REG_CTRL, 32'h00000001);
    wait_cyc(3);
    chk("net lost", 32'h0, {31'h0, net});
    // no clock edge passes between kill and the check
    wr_reg(REG_CTRL, 32'h00000000);
    chk("kill run", 32'h0, {31'h0, run});
    chk("kill pins", 32'hFFF, {20'h0, link.dev_pin_oe_n});
    wr_reg(REG_CTRL, 32'h00000001);
    $display("test kill done");
    // profile 0 pins: host drives scl, irq, radio off and tries the blank pin
    @(posedge core_clk);
    sda_low <= 1'b1;
    swamp <= 1'b1;
    act <= 1'b1;
    gp_drv <= 12'h060;
    gp_out <= 12'h040;
    wr_reg(REG_PIN_OUT, 32'h00000000);
    wr_reg(REG_PIN_DRV, 32'h00000415);
    wait_cyc(3);
    rd_reg(REG_PIN_IN, 32'h000009D0, 32'hFF7, "pins a");
    chk("gp in", 32'h9D0, {20'h0, gp_in & 12'hFF7});
    chk("scl", 32'h0, {31'h0, scl});
    chk("sda", 32'h0, {31'h0, sda});
    chk("irq host", 32'h1, {31'h0, irq});
    chk("radio off", 32'h1, {31'h0, roff});
    @(posedge core_clk);
    sda_low <= 1'b0;
    swamp <= 1'b0;
    act <= 1'b0;
    gp_drv <= 12'h000;
    irq_req <= 1'b1;
    wr_reg(REG_PIN_DRV, 32'h00000000);
    wait_cyc(3);
    rd_reg(REG_PIN_IN, 32'h00000FEB, 32'hFF7, "pins b");
    chk("irq card", 32'h1, {31'h0, irq});
    $display("test pins done");
    // wake pulse, with a second request inside it that must be ignored
    @(posedge core_clk);
    irq_req <= 1'b0;
    wake_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    w = 0;
    n = 0;
    #1;
    while (busy !== 1'b1 && w < 4) begin
      wait_cyc(1);
      w++;
    end
    while (busy === 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
      wake_req <= (n == 5);
      #1;
      // the pin follows the busy flag one edge later
      if (n == 1) chk("wake pin low", 32'h0, {31'h0, link.pin_level[11]});
    end
    chk("wake length", WAKE_N, n);
    wait_cyc(1);
    chk("wake pin free", 32'h1, {31'h0, link.pin_level[11]});
    rd_reg(REG_STATUS, 32'h00001022, ALL, "wake seen");
    wr_reg(REG_STATUS, 32'h00001000);
    rd_reg(REG_STATUS, 32'h00000022, ALL, "wake clear");
    $display("test wake done");
    // proximity: a short glitch is filtered, a steady level cuts power
    wr_reg(REG_CTRL, 32'h00000005);
    @(posedge core_clk);
    prox <= 1'b1;
    repeat (PROX_N - 4) @(posedge core_clk);
    prox <= 1'b0;
    wait_cyc(12);
    chk("cut glitch", 32'h0, {31'h0, cut});
    @(posedge core_clk);
    prox <= 1'b1;
    wait_cyc(PROX_N + 6);
    chk("cut on", 32'h1, {31'h0, cut});
    rd_reg(REG_STATUS, 32'h00002022, ALL, "prox status");
    @(posedge core_clk);
    prox <= 1'b0;
    wait_cyc(PROX_N + 6);
    chk("cut off", 32'h0, {31'h0, cut});
    $display("test proximity done");
    finish_test();
  end
endmodule
